// >>> tb/lfp_mac_model.sv
// mac-side partner: sends rx frames, takes words from tx staging
// assumes: bench commands arrive by nba on mclk rising edges
`timescale 1ns/1ps
`default_nettype none
module lfp_mac_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic rx_go,
	input wire logic [7:0] rx_len,
	input wire logic tx_go,
	input wire logic [7:0] tx_len,
	output logic mac_rx_valid,
	output logic [31:0] mac_rx_data,
	output logic mac_rx_last,
	output logic mac_tx_rd,
	output logic mac_tx_last,
	output logic busy
);
	logic [7:0] rx_left;
	logic [7:0] tx_left;
	logic [31:0] word;
	// ----------------------------------------------------------
	// rx sender: back to back words, no stall, like a real mac
	// ----------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rx_left <= 8'h00;
			word <= 32'hC0DE0000;
		end else if (rx_go) begin
			rx_left <= rx_len;
		end else if (rx_left != 8'h00) begin
			rx_left <= rx_left - 8'h01;
			word <= word + 32'h00000001;
		end
	end
	// ----------------------------------------------------------
	// tx taker: one word a cycle, last flag on the final word
	// ----------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn)
			tx_left <= 8'h00;
		else if (tx_go)
			tx_left <= tx_len;
		else if (tx_left != 8'h00)
			tx_left <= tx_left - 8'h01;
	end
	assign mac_rx_valid = rx_left != 8'h00;
	// idle data inverted so a stale word can never pass as fresh
	assign mac_rx_data = mac_rx_valid ? word : ~word;
	assign mac_rx_last = rx_left == 8'h01;
	assign mac_tx_rd = tx_left != 8'h00;
	assign mac_tx_last = tx_left == 8'h01;
	assign busy = mac_rx_valid | mac_tx_rd;
endmodule // lfp_mac_model
`default_nettype wire

// >>> tb/lfp_rx_partition_tb.sv
// self-checking bench for the buffer partition and rx datapath
// assumes: apb master, host fifo strobes and mac model on mclk
`timescale 1ns/1ps
`default_nettype none
module lfp_rx_partition_tb;
	logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, rxd_wr_en, rxs_valid, txd_pop;
	logic [7:0] paddr = 8'h00, rx_len = 8'h00, tx_len = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rxd_wr_data, mac_rx_data, r;
	logic mac_rx_valid, mac_rx_last, mac_tx_rd, mac_tx_last, busy, e;
	logic host_rxd_rd = 1'b0, host_rxs_rd = 1'b0, rx_go = 1'b0;
	logic tx_go = 1'b0, txd_avail = 1'b0, txd_last = 1'b0;
	logic [15:0] rxs_data, tx_data_size, rx_data_size, rx_status_size;
	logic [31:0] last_wr;
	logic [63:0] rows [13];
	int n_fail = 0, n_compared = 0, n_wr = 0, n_tx = 0;
	always #4 mclk = ~mclk;
	lfp_rx_partition u_lfp_rx_partition (.mclk(mclk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mac_rx_valid(mac_rx_valid),
		.mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last),
		.rxd_wr_en(rxd_wr_en), .rxd_wr_data(rxd_wr_data),
		.host_rxd_rd(host_rxd_rd), .host_rxs_rd(host_rxs_rd),
		.rxs_valid(rxs_valid), .rxs_data(rxs_data),
		.txd_avail(txd_avail), .txd_last(txd_last), .txd_pop(txd_pop),
		.mac_tx_rd(mac_tx_rd), .mac_tx_last(mac_tx_last),
		.tx_data_size(tx_data_size), .rx_data_size(rx_data_size),
		.rx_status_size(rx_status_size));
	lfp_mac_model u_lfp_mac_model (.mclk(mclk), .rstn(rstn),
		.rx_go(rx_go), .rx_len(rx_len), .tx_go(tx_go), .tx_len(tx_len),
		.mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data),
		.mac_rx_last(mac_rx_last), .mac_tx_rd(mac_tx_rd),
		.mac_tx_last(mac_tx_last), .busy(busy));
	always @(posedge mclk) begin
		if (rxd_wr_en === 1'b1) begin
			n_wr++;
			last_wr = rxd_wr_data;
		end
		if (txd_pop === 1'b1)
			n_tx++;
	end
	// ----------------------------------------------------------
	// tasks: all return just after a rising edge
	// ----------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// keep=1 leaves psel up so the next setup follows at once
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic keep);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog ends a stuck access
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		penable <= 1'b0;
		if (!keep) begin
			psel <= 1'b0;
			@(posedge mclk);
		end
	endtask
	task automatic reset_dut();
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		n_wr = 0;
		n_tx = 0;
	endtask
	task automatic settle(input int n);
		for (int i = 0; i < 400; i++) begin
			@(negedge mclk);
			if (busy === 1'b0)
				break;
		end
		repeat (n) @(posedge mclk);
	endtask
	task automatic send(input logic [7:0] n);
		rx_go <= 1'b1;
		rx_len <= n;
		@(posedge mclk);
		rx_go <= 1'b0;
		settle(1);
	endtask
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		rows = '{64'h0002_0600_3480_0380, 64'h0003_0A00_30C0_0340,
			64'h0004_0E00_2D00_0300, 64'h0005_1200_2940_02C0,
			64'h0006_1600_2580_0280, 64'h0007_1A00_21C0_0240,
			64'h0008_1E00_1E00_0200, 64'h0009_2200_1A40_01C0,
			64'h000A_2600_1680_0180, 64'h000B_2A00_12C0_0140,
			64'h000C_2E00_0F00_0100, 64'h000D_3200_0B40_00C0,
			64'h000E_3600_0780_0080};
		reset_dut();
		repeat (2) @(posedge mclk);
		apb(1'b0, 8'h74, 32'h0, 1'b0);
		chk("alloc reset", 32'h5, r);
		apb(1'b0, 8'h78, 32'h0, 1'b0);
		chk("ctrl reset", 32'h0, r);
		apb(1'b0, 8'h7C, 32'h0, 1'b0);
		chk("info reset", 32'h0, r);
		apb(1'b0, 8'h70, 32'h0, 1'b0);
		chk("drop reset", 32'h0, r);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, 8'h74, {16'h0, rows[i][63:48]}, 1'b0);
			repeat (3) @(posedge mclk);
			chk("tx data size", rows[i][47:32], tx_data_size);
			chk("rx data size", rows[i][31:16], rx_data_size);
			chk("rx stat size", rows[i][15:0], rx_status_size);
		end
		$display("test partition table done");
		apb(1'b1, 8'h74, 32'h5, 1'b0);
		apb(1'b0, 8'h00, 32'h0, 1'b0);
		chk("unmapped err", 32'h1, e);
		chk("unmapped data", 32'h0, r);
		apb(1'b1, 8'h7C, 32'hFFFFFFFF, 1'b0);
		send(8'd3);
		repeat (6) @(posedge mclk);
		chk("words moved", 32'd3, n_wr);
		chk("last word", 32'hC0DE0002, last_wr);
		apb(1'b0, 8'h7C, 32'h0, 1'b0);
		chk("info one frame", 32'h0001000C, r);
		chk("status valid", 32'h1, rxs_valid);
		chk("status word", 32'h000C, rxs_data);
		host_rxd_rd <= 1'b1;
		host_rxs_rd <= 1'b1;
		@(posedge mclk);
		host_rxs_rd <= 1'b0;
		repeat (2) @(posedge mclk);
		host_rxd_rd <= 1'b0;
		repeat (2) @(posedge mclk);
		apb(1'b0, 8'h7C, 32'h0, 1'b0);
		chk("info drained", 32'h0, r);
		$display("test rx frame done");
		send(8'd2);
		repeat (6) @(posedge mclk);
		apb(1'b1, 8'h78, 32'h80000000, 1'b1);
		apb(1'b0, 8'h78, 32'h0, 1'b0);
		chk("skip busy", 32'h80000000, r);
		repeat (3) @(posedge mclk);
		apb(1'b0, 8'h78, 32'h0, 1'b0);
		chk("skip done", 32'h0, r);
		apb(1'b0, 8'h7C, 32'h0, 1'b0);
		chk("skip used", 32'h0, {16'h0, r[15:0]});
		$display("test skip done");
		reset_dut();
		apb(1'b1, 8'h74, 32'hE, 1'b0);
		for (int i = 0; i < 16; i++)
			send(8'd34);
		repeat (8) @(posedge mclk);
		apb(1'b0, 8'h70, 32'h0, 1'b0);
		chk("dropped frames", 32'h2, r);
		apb(1'b0, 8'h7C, 32'h0, 1'b0);
		chk("info full", 32'h000E0770, r);
		$display("test overrun done");
		reset_dut();
		txd_avail <= 1'b1;
		txd_last <= 1'b1;
		repeat (20) @(posedge mclk);
		chk("two frames", 32'd2, n_tx);
		tx_go <= 1'b1;
		tx_len <= 8'd1;
		@(posedge mclk);
		tx_go <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("refill", 32'd3, n_tx);
		// no pop may straddle the release edge and the count clear
		txd_avail <= 1'b0;
		txd_last <= 1'b0;
		reset_dut();
		txd_avail <= 1'b1;
		repeat (600) @(posedge mclk);
		chk("tx stage words", 32'd512, n_tx);
		txd_avail <= 1'b0;
		$display("test tx staging done");
		finish_test();
	end
endmodule // lfp_rx_partition_tb
`default_nettype wire

// >>> verilog/lfp_alloc.sv
// derives both region sizes and three fifo sizes from the transmit allocation setting
// assumes: setting is held in a register of the same clock
`timescale 1ns/1ps
`default_nettype none
module lfp_alloc (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [lfp_pkg::ALLOC_W-1:0] alloc,
	output logic [15:0] tx_total,
	output logic [15:0] tx_data,
	output logic [15:0] rx_total,
	output logic [15:0] rx_stat,
	output logic [15:0] rx_data
);
	logic [15:0] next_tx_total;
	logic [15:0] next_rx_total;
	logic [15:0] next_rx_stat;

	// whole 16 kbyte shared buffer, reserved settings not trapped
	assign next_tx_total = 16'({12'h000, alloc} << lfp_pkg::KB_SHIFT);
	assign next_rx_total = lfp_pkg::BUF_BYTES - next_tx_total;
	assign next_rx_stat = next_rx_total >> lfp_pkg::RXS_SHIFT;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_total <= '0;
			tx_data <= '0;
			rx_total <= '0;
			rx_stat <= '0;
			rx_data <= '0;
		end else begin
			tx_total <= next_tx_total;
			tx_data <= next_tx_total - lfp_pkg::TXS_BYTES;
			rx_total <= next_rx_total;
			rx_stat <= next_rx_stat;
			rx_data <= next_rx_total - next_rx_stat;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_tx_total;
		$past(rstn) |-> tx_total == 16'({12'h000, $past(alloc)} << 10);
	endproperty
	a_tx_total: assert property (p_tx_total)
		else $error("tx total not setting times 1024");
	property p_tx_data;
		$past(rstn) |-> tx_data + 16'h0200 == tx_total;
	endproperty
	a_tx_data: assert property (p_tx_data)
		else $error("tx status part not 512 bytes");
	property p_rx_total;
		$past(rstn) |-> rx_total + tx_total == 16'h4000;
	endproperty
	a_rx_total: assert property (p_rx_total)
		else $error("rx region not remainder");
	property p_rx_stat;
		$past(rstn) |-> {rx_stat, 4'h0} == {4'h0, rx_total};
	endproperty
	a_rx_stat: assert property (p_rx_stat)
		else $error("rx status not one sixteenth");
	property p_rx_data;
		$past(rstn) |-> rx_data + rx_stat == rx_total;
	endproperty
	a_rx_data: assert property (p_rx_data)
		else $error("rx data size wrong");
endmodule // lfp_alloc
`default_nettype wire

// >>> verilog/lfp_fifo.sv
// small flip-flop fifo used for staging and frame records
// assumes: same clock on both sides, pops only while out_valid
`timescale 1ns/1ps
`default_nettype none
module lfp_fifo #(
	parameter int W = 8,
	parameter int AW = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [AW:0] count
);
	localparam logic [AW:0] FULL = (AW+1)'(2**AW);
	logic [W-1:0] mem [2**AW];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic push;
	logic pop;

	assign in_ready = count != FULL;
	assign out_valid = count != '0;
	assign out_data = mem[rp];
	assign push = in_valid & in_ready;
	assign pop = out_ready & out_valid;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			case ({push, pop})
				2'b10: count <= count + 1'b1;
				2'b01: count <= count - 1'b1;
				default: count <= count;
			endcase
		end
	end

	property p_fifo_bound;
		@(posedge mclk) disable iff (!rstn)
		count == FULL && !pop |=> count == FULL;
	endproperty
	a_fifo_bound: assert property (p_fifo_bound)
		else $error("fifo level moved while full");
endmodule // lfp_fifo
`default_nettype wire

// >>> verilog/lfp_pkg.sv
// constants for the rx/tx buffer partition and rx datapath block
// assumes: one clock domain, apb register access, 32-bit words
package lfp_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_DROP = 8'h70;
	localparam logic [7:0] OFF_CFG = 8'h74;
	localparam logic [7:0] OFF_CTRL = 8'h78;
	localparam logic [7:0] OFF_INFO = 8'h7C;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int ALLOC_W = 4;
	localparam logic [3:0] CFG_ALLOC_RST = 4'h5;
	localparam int FFWD_BIT = 31;
	localparam logic [15:0] RX_USED_RST = 16'h0000;
	localparam logic [7:0] RXS_USED_RST = 8'h00;

	// ------------------------------------------------------------
	// buffer sizes
	// ------------------------------------------------------------
	localparam logic [15:0] BUF_BYTES = 16'h4000;
	localparam logic [15:0] TXS_BYTES = 16'h0200;
	localparam int KB_SHIFT = 10;
	localparam int RXS_SHIFT = 4;
	localparam logic [15:0] RXD_FULL_MARGIN = 16'h0010;
	localparam logic [15:0] WORD_BYTES = 16'h0004;
	localparam logic [9:0] TX_STAGE_WORDS = 10'h200;
	localparam logic [1:0] TX_STAGE_FRAMES = 2'h2;
	localparam int RX_STAGE_AW = 5;
	localparam int FRQ_AW = 4;

	// ------------------------------------------------------------
	// mac intake state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LFP_IDLE = 3'b001,
		LFP_PASS = 3'b010,
		LFP_SKIP = 3'b100
	} lfp_rx_st_t;

endpackage

// >>> verilog/lfp_rx_partition.sv
// buffer partition, mac staging and rx datapath with apb registers
// assumes: mac, host fifo ports and apb master all on mclk
// What this block does
// - tx status fifo is always 512 bytes inside the tx region
// - tx region equals setting times 1024 bytes
// - tx data fifo is tx region minus status, holds commands
// - rx region is 16384 minus tx region
// - rx status fifo is one sixteenth of rx region
// - rx data fifo is rx region minus rx status
// - rx data fifo is full four words before its length
// - fixed staging of 2k bytes tx and 128 bytes rx
// - refill tx staging as room frees, at most two frames
// - rx data goes mac to staging to fifo, waits while full
// - on staging overrun drop frames until room, count each
// - staging levels hidden and excluded from host levels
// - writing bit 31 of control skips to next frame
// - skip bit reads one while busy, self clears, resets zero
// - info bits 23-16 give rx status words used
// - info bits 15-0 give rx data bytes used, word rounded
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lfp_rx_partition (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mac_rx_valid,
	input wire logic [31:0] mac_rx_data,
	input wire logic mac_rx_last,
	output logic rxd_wr_en,
	output logic [31:0] rxd_wr_data,
	input wire logic host_rxd_rd,
	input wire logic host_rxs_rd,
	output logic rxs_valid,
	output logic [15:0] rxs_data,
	input wire logic txd_avail,
	input wire logic txd_last,
	output logic txd_pop,
	input wire logic mac_tx_rd,
	input wire logic mac_tx_last,
	output logic [15:0] tx_data_size,
	output logic [15:0] rx_data_size,
	output logic [15:0] rx_status_size
);
	logic [3:0] alloc;
	logic ffwd;
	logic [15:0] drop_cnt;
	logic [15:0] used;
	logic [11:0] wcnt;
	logic [11:0] rd_left;
	logic close_pend;
	logic drop_mode;
	lfp_pkg::lfp_rx_st_t rx_st;
	lfp_pkg::lfp_rx_st_t next_rx_st;
	logic [9:0] tx_words;
	logic [1:0] tx_frames;
	logic [15:0] tx_total;
	logic [15:0] rx_total;

	// ------------------------------------------------------------
	// partition sizes
	// ------------------------------------------------------------
	lfp_alloc u_alloc (
		.mclk(mclk),
		.rstn(rstn),
		.alloc(alloc),
		.tx_total(tx_total),
		.tx_data(tx_data_size),
		.rx_total(rx_total),
		.rx_stat(rx_status_size),
		.rx_data(rx_data_size)
	);

	// ------------------------------------------------------------
	// rx staging buffer, 128 bytes, plus frame records
	// ------------------------------------------------------------
	logic stg_wr;
	logic [33:0] stg_din;
	logic stg_room;
	logic stg_v;
	logic [33:0] stg_q;
	logic mv;
	logic rx_full;
	logic fr_push;
	logic stq_rdy;
	logic lnq_rdy;
	logic [12:0] rxs_q;
	logic [4:0] stq_cnt;
	logic lq_v;
	logic [11:0] lq_len;
	logic lq_pop;
	logic [11:0] fr_len;

	lfp_fifo #(.W(34), .AW(lfp_pkg::RX_STAGE_AW)) u_stage (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(stg_wr),
		.in_data(stg_din),
		.in_ready(stg_room),
		.out_valid(stg_v),
		.out_data(stg_q),
		.out_ready(mv),
		.count()
	);

	lfp_fifo #(.W(13), .AW(lfp_pkg::FRQ_AW)) u_stq (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(fr_push),
		.in_data({stg_q[33], fr_len}),
		.in_ready(stq_rdy),
		.out_valid(rxs_valid),
		.out_data(rxs_q),
		.out_ready(host_rxs_rd),
		.count(stq_cnt)
	);

	lfp_fifo #(.W(12), .AW(lfp_pkg::FRQ_AW)) u_lnq (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(fr_push),
		.in_data(fr_len),
		.in_ready(lnq_rdy),
		.out_valid(lq_v),
		.out_data(lq_len),
		.out_ready(lq_pop),
		.count()
	);

	// status word: error flag, spare, length in bytes
	assign rxs_data = {rxs_q[12], 1'b0, rxs_q[11:0], 2'b00};
	assign fr_len = wcnt + 12'h001;

	// staging words never count toward used
	assign rx_full = used >= rx_data_size - lfp_pkg::RXD_FULL_MARGIN;
	assign mv = stg_v & ~rx_full &
		(~stg_q[32] | (stq_rdy & lnq_rdy));
	assign fr_push = mv & stg_q[32];

	// ------------------------------------------------------------
	// mac intake and overrun dropping
	// ------------------------------------------------------------
	logic sof_drop;
	logic acc;
	logic ovr;
	logic drop_ev;

	assign sof_drop = rx_st == lfp_pkg::LFP_IDLE && drop_mode;
	assign acc = mac_rx_valid && rx_st != lfp_pkg::LFP_SKIP && !sof_drop
		&& stg_room;
	assign ovr = mac_rx_valid && rx_st != lfp_pkg::LFP_SKIP && !sof_drop
		&& !stg_room;
	assign drop_ev = mac_rx_valid && (sof_drop || ovr);
	// a cut frame is closed by a dummy word so the host sees its end
	assign stg_wr = acc | (close_pend & stg_room);
	assign stg_din = acc ? {1'b0, mac_rx_last, mac_rx_data}
		: {2'b11, 32'h0000_0000};

	always_comb begin
		next_rx_st = rx_st;
		case (rx_st)
			lfp_pkg::LFP_IDLE, lfp_pkg::LFP_PASS, lfp_pkg::LFP_SKIP: begin
				if (mac_rx_valid) begin
					if (mac_rx_last) begin
						next_rx_st = lfp_pkg::LFP_IDLE;
					end else if (acc) begin
						next_rx_st = lfp_pkg::LFP_PASS;
					end else begin
						next_rx_st = lfp_pkg::LFP_SKIP;
					end
				end
			end
			default: next_rx_st = lfp_pkg::LFP_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rx_st <= lfp_pkg::LFP_IDLE;
		end else begin
			rx_st <= next_rx_st;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			close_pend <= 1'b0;
			drop_mode <= 1'b0;
		end else begin
			if (ovr && rx_st == lfp_pkg::LFP_PASS) begin
				close_pend <= 1'b1;
			end else if (stg_room) begin
				close_pend <= 1'b0;
			end
			// set wins; release only once the data fifo has room
			if (ovr) begin
				drop_mode <= 1'b1;
			end else if (!rx_full && !close_pend) begin
				drop_mode <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			drop_cnt <= '0;
		end else if (drop_ev) begin
			drop_cnt <= drop_cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// move into rx data fifo
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wcnt <= '0;
			rxd_wr_en <= 1'b0;
			rxd_wr_data <= '0;
		end else begin
			rxd_wr_en <= mv;
			if (mv) begin
				rxd_wr_data <= stg_q[31:0];
				wcnt <= stg_q[32] ? 12'h000 : fr_len;
			end
		end
	end

	// ------------------------------------------------------------
	// host reads, fast-forward and used count
	// ------------------------------------------------------------
	logic rd_ok;
	logic ff_go;
	logic [11:0] skip_w;
	logic [15:0] next_used;

	// reads during a skip are not guarded; host keeps off them
	assign ff_go = ffwd;
	assign rd_ok = host_rxd_rd && (rd_left != 12'h000 || lq_v);
	assign lq_pop = rd_left == 12'h000 && ((rd_ok && !ff_go) || (ff_go && lq_v));

	always_comb begin
		skip_w = 12'h000;
		if (ff_go) begin
			skip_w = rd_left != 12'h000 ? rd_left : (lq_v ? lq_len : 12'h000);
		end else if (rd_ok) begin
			skip_w = 12'h001;
		end
		next_used = used + (mv ? lfp_pkg::WORD_BYTES : 16'h0000)
			- {2'b00, skip_w, 2'b00};
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			used <= lfp_pkg::RX_USED_RST;
			rd_left <= '0;
		end else begin
			used <= next_used;
			if (ff_go) begin
				rd_left <= 12'h000;
			end else if (rd_ok) begin
				rd_left <= (rd_left == 12'h000 ? lq_len : rd_left) - 12'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// tx staging refill, 2k bytes
	// ------------------------------------------------------------
	logic tx_rd;

	assign txd_pop = txd_avail && tx_words < lfp_pkg::TX_STAGE_WORDS
		&& tx_frames < lfp_pkg::TX_STAGE_FRAMES;
	assign tx_rd = mac_tx_rd && tx_words != 10'h000;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_words <= '0;
			tx_frames <= '0;
		end else begin
			tx_words <= tx_words + {9'h000, txd_pop} - {9'h000, tx_rd};
			case ({txd_pop & txd_last, tx_rd & mac_tx_last})
				2'b10: tx_frames <= tx_frames + 2'h1;
				2'b01: tx_frames <= tx_frames - 2'h1;
				default: tx_frames <= tx_frames;
			endcase
		end
	end

	// ------------------------------------------------------------
	// apb registers
	// ------------------------------------------------------------
	logic wr;
	logic hit;

	assign wr = psel & penable & pwrite;
	assign hit = paddr == lfp_pkg::OFF_DROP || paddr == lfp_pkg::OFF_CFG
		|| paddr == lfp_pkg::OFF_CTRL || paddr == lfp_pkg::OFF_INFO;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			alloc <= lfp_pkg::CFG_ALLOC_RST;
			ffwd <= 1'b0;
		end else begin
			if (wr && paddr == lfp_pkg::OFF_CFG) begin
				alloc <= pwdata[3:0];
			end
			// a second write while busy is ignored, not queued
			if (ff_go) begin
				ffwd <= 1'b0;
			end else if (wr && paddr == lfp_pkg::OFF_CTRL
				&& pwdata[lfp_pkg::FFWD_BIT]) begin
				ffwd <= 1'b1;
			end
		end
	end

	// read data latched in the setup cycle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			case (paddr)
				lfp_pkg::OFF_DROP: prdata <= {16'h0000, drop_cnt};
				lfp_pkg::OFF_CFG: prdata <= {28'h0000000, alloc};
				lfp_pkg::OFF_CTRL: prdata <= {ffwd, 31'h00000000};
				lfp_pkg::OFF_INFO: prdata <= {8'h00, 3'h0, stq_cnt, used};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_ffwd_req;
		wr && paddr == 8'h78 && pwdata[31] && !ffwd;
	endsequence
	sequence s_ffwd_done;
		ffwd ##1 !ffwd;
	endsequence
	property p_ffwd;
		s_ffwd_req |=> s_ffwd_done;
	endproperty
	a_ffwd: assert property (p_ffwd)
		else $error("skip bit did not set then clear");
	property p_full_hold;
		rx_full && stg_v |=> !rxd_wr_en;
	endproperty
	a_full_hold: assert property (p_full_hold)
		else $error("moved data into a full rx fifo");
	property p_drop_cnt;
		drop_ev |=> drop_cnt == $past(drop_cnt) + 16'h0001;
	endproperty
	a_drop_cnt: assert property (p_drop_cnt)
		else $error("dropped frame not counted");
	property p_drop_block;
		sof_drop && mac_rx_valid |-> !acc ##1 rx_st != lfp_pkg::LFP_PASS;
	endproperty
	a_drop_block: assert property (p_drop_block)
		else $error("frame admitted while dropping");
	property p_used_grow;
		mv && !rd_ok && !ffwd |=> used == $past(used) + 16'h0004;
	endproperty
	a_used_grow: assert property (p_used_grow)
		else $error("used bytes did not grow by a word");
	property p_used_read;
		rd_ok && !mv && !ffwd |=> used == $past(used) - 16'h0004;
	endproperty
	a_used_read: assert property (p_used_read)
		else $error("used bytes did not drop on read");
	property p_tx_limit;
		tx_frames == 2'h2 || tx_words == 10'h200 |-> !txd_pop;
	endproperty
	a_tx_limit: assert property (p_tx_limit)
		else $error("tx staging overfilled");
	property p_info;
		psel && !penable && paddr == 8'h7C |=>
			prdata[15:0] == $past(used) && prdata[23:16] == $past(stq_cnt);
	endproperty
	a_info: assert property (p_info)
		else $error("info register mismatch");
endmodule // lfp_rx_partition
`default_nettype wire
